// >>> core/sdf_pkg.sv
package sdf_pkg;
  // Frame geometry
  localparam int unsigned SDF_FRAME_BYTES = 2064;
  localparam logic [3:0] SDF_LAST_ROW = 4'hb;
  localparam logic [7:0] SDF_LAST_COL = 8'hab;
  localparam logic [7:0] SDF_HEAD_LAST_COL = 8'h0b;
  localparam logic [7:0] SDF_USER_LAST_COL_END = 8'ha7;
  localparam logic [7:0] SDF_EDC_FIRST_COL = 8'ha8;
  // Header columns inside row zero
  localparam logic [7:0] SDF_COL_ID_LAST = 8'h03;
  localparam logic [7:0] SDF_COL_CHECK_HI = 8'h04;
  localparam logic [7:0] SDF_COL_CHECK_LO = 8'h05;
  localparam logic [7:0] SDF_COL_RSV_FIRST = 8'h06;
  // Fixed sector information bits 31..28: format, tracking, reflectivity, reserved
  localparam logic [3:0] SDF_INFO_FIXED = 4'h2;
  // Field polynomial low byte and the two check generator coefficients
  localparam logic [7:0] SDF_GF_POLY = 8'h1d;
  localparam logic [7:0] SDF_GE_C1 = 8'h03;
  localparam logic [7:0] SDF_GE_C0 = 8'h02;
  // Frame check word generator without the x^32 term
  localparam logic [31:0] SDF_EDC_POLY = 32'h8000_0011;
  // Register byte offsets
  localparam logic [7:0] SDF_REG_CTRL = 8'h00;
  localparam logic [7:0] SDF_REG_SECTOR_NUM = 8'h04;
  localparam logic [7:0] SDF_REG_SECTOR_INFO = 8'h08;
  localparam logic [7:0] SDF_REG_RSV_HI = 8'h0c;
  localparam logic [7:0] SDF_REG_RSV_LO = 8'h10;
  localparam logic [7:0] SDF_REG_STATUS = 8'h14;
  localparam logic [7:0] SDF_REG_FRAMES = 8'h18;
  localparam logic [7:0] SDF_REG_LAST_EDC = 8'h1c;
  // Bus responses
  localparam logic [1:0] SDF_RESP_OKAY = 2'h0;
  localparam logic [1:0] SDF_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SDF_ST_IDLE = 2'b00,
    SDF_ST_HEAD = 2'b01,
    SDF_ST_DATA = 2'b10,
    SDF_ST_EDC = 2'b11
  } sdf_state_t;
endpackage

// >>> core/sdf_core_if.sv
interface sdf_core_if;
  import sdf_pkg::*;
  logic [31:0] id_word;
  logic [15:0] check_word;
  logic crc_clear;
  logic crc_step;
  logic [7:0] crc_byte;
  logic [31:0] crc_word;
  modport builder (output id_word, output crc_clear, output crc_step, output crc_byte,
                   input check_word, input crc_word);
  modport check_unit (input id_word, output check_word);
  modport crc_unit (input crc_clear, input crc_step, input crc_byte, output crc_word);
endinterface

// >>> core/sdf_id_check.sv
module sdf_id_check import sdf_pkg::*; (
  sdf_core_if.check_unit bus
);
  // Multiply by alpha in the field
  function automatic logic [7:0] sdf_xtime(input logic [7:0] v);
    sdf_xtime = {v[6:0], 1'b0} ^ (v[7] ? SDF_GF_POLY : 8'h00);
  endfunction

  // General field product, shift and add
  function automatic logic [7:0] sdf_gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] sh;
    acc = 8'h00;
    sh = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        acc = acc ^ sh;
      end
      sh = sdf_xtime(sh);
    end
    sdf_gf_mul = acc;
  endfunction

  always_comb begin
    logic [7:0] r1;
    logic [7:0] r0;
    logic [7:0] fb;
    r1 = 8'h00;
    r0 = 8'h00;
    fb = 8'h00;
    for (int k = 3; k >= 0; k--) begin
      fb = bus.id_word[k*8 +: 8] ^ r1;
      r1 = r0 ^ sdf_gf_mul(fb, SDF_GE_C1);
      r0 = sdf_gf_mul(fb, SDF_GE_C0);
    end
    bus.check_word = {r1, r0};
  end
endmodule

// >>> core/sdf_edc_crc.sv
module sdf_edc_crc import sdf_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  sdf_core_if.crc_unit bus
);
  typedef struct packed {
    logic [31:0] crc;
  } sdf_crc_state_t;

  sdf_crc_state_t r_q;
  sdf_crc_state_t r_d;

  always_comb begin
    logic [31:0] c;
    c = r_q.crc;
    for (int i = 7; i >= 0; i--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ bus.crc_byte[i]) ? SDF_EDC_POLY : 32'h0000_0000);
    end
    r_d = r_q;
    if (bus.crc_clear) begin
      r_d.crc = 32'h0000_0000;
    end else if (bus.crc_step) begin
      r_d.crc = c;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign bus.crc_word = r_q.crc;
endmodule

// >>> core/sdf_frame_builder.sv
// What this block does
// - Frame is 2064 bytes, 12 rows of 172
// - Row zero: id, check, reserved, 160 user
// - Middle rows full user; last ends with check
// - User bytes placed strictly in arrival order
// - Identifier four bytes, top byte sent first
// - Low 24 bits carry the sector number
// - Bits 31, 30, 28 always zero
// - Bit 29 always one
// - Bits 27..26 encode the zone
// - Bit 25 marks linking sectors
// - Sector information bits 27..24 emitted as software wrote them, unchecked
// - Two identifier check bytes from RS remainder
// - Check arithmetic over the 0x11d field
// - Reserved bytes zero unless software sets them
// - Frame check word over first 2060 bytes
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
module sdf_frame_builder import sdf_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] user_data,
  input wire logic user_valid,
  output logic user_ready,
  output logic [7:0] frame_data,
  output logic frame_valid,
  output logic frame_first,
  output logic frame_last,
  input wire logic frame_ready
);
  typedef struct packed {
    sdf_state_t st;
    logic [3:0] row;
    logic [7:0] col;
    logic out_valid;
    logic [7:0] out_data;
    logic out_first;
    logic out_last;
    logic [31:0] id;
    logic [47:0] rsv_lat;
    logic enable;
    logic auto_inc;
    logic [23:0] sec_num;
    logic [3:0] info;
    logic [47:0] reserved_field;
    logic [31:0] frames;
    logic [31:0] last_edc;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sdf_regs_t;

  sdf_regs_t r_q;
  sdf_regs_t r_d;
  sdf_core_if core ();

  // Top byte index of the 32-bit words and of the six-byte reserved field
  localparam logic [1:0] SDF_WORD_TOP = 2'h3;
  localparam logic [2:0] SDF_RSV_TOP = 3'h5;

  // Byte-enable merge, used by every writable register
  function automatic logic [31:0] sdf_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    sdf_merge = m;
  endfunction

  // Column and row advance after one emitted byte
  function automatic logic [11:0] sdf_advance(input logic [3:0] row, input logic [7:0] col);
    if (col == SDF_LAST_COL) begin
      sdf_advance = {row + 4'h1, 8'h00};
    end else begin
      sdf_advance = {row, col + 8'h01};
    end
  endfunction

  // Byte of a 32-bit word counted from its top; serves identifier and check word
  function automatic logic [7:0] sdf_top_byte(input logic [31:0] w, input logic [1:0] pos);
    sdf_top_byte = w[(SDF_WORD_TOP - pos)*8 +: 8];
  endfunction

  // Word offset of a byte address; writes and reads decode alike
  function automatic logic [7:0] sdf_word_addr(input logic [7:0] a);
    sdf_word_addr = {a[7:2], 2'b00};
  endfunction

  sdf_id_check u_id_check (
    .bus(core.check_unit)
  );

  sdf_edc_crc u_edc_crc (
    .ref_clk(ref_clk),
    .reset(reset),
    .bus(core.crc_unit)
  );

  logic can_load;
  logic [7:0] head_byte;
  logic [7:0] edc_byte;
  logic [7:0] rsv_idx;

  // Output stage may load when empty or being drained this cycle
  assign can_load = !r_q.out_valid || frame_ready;
  // user input only flows during the payload
  assign user_ready = (r_q.st == SDF_ST_DATA) && can_load;
  assign rsv_idx = r_q.col - SDF_COL_RSV_FIRST;
  assign core.id_word = r_q.id;

  // Header byte select for row zero
  always_comb begin
    head_byte = 8'h00;
    if (r_q.col <= SDF_COL_ID_LAST) begin
      head_byte = sdf_top_byte(r_q.id, r_q.col[1:0]);
    end else if (r_q.col == SDF_COL_CHECK_HI) begin
      head_byte = core.check_word[15:8];
    end else if (r_q.col == SDF_COL_CHECK_LO) begin
      head_byte = core.check_word[7:0];
    end else begin
      head_byte = r_q.rsv_lat[(SDF_RSV_TOP - rsv_idx[2:0])*8 +: 8];
    end
  end

  // Check word bytes, most significant first
  assign edc_byte = sdf_top_byte(core.crc_word, r_q.col[1:0]);

  // Next-state logic for framing and the register slave
  always_comb begin
    logic [11:0] adv;
    logic emit;
    adv = sdf_advance(r_q.row, r_q.col);
    emit = 1'b0;
    r_d = r_q;
    core.crc_clear = 1'b0;
    core.crc_step = 1'b0;
    core.crc_byte = 8'h00;

    // Drained output byte leaves the stage
    if (r_q.out_valid && frame_ready) begin
      r_d.out_valid = 1'b0;
    end

    case (r_q.st)
      SDF_ST_IDLE: begin
        // Seed for a new frame; a fresh clear also covers an aborted previous one
        core.crc_clear = 1'b1;
        // Enable is only looked at here, so clearing it never cuts a frame short
        if (r_q.enable && user_valid) begin
          r_d.id = {SDF_INFO_FIXED, r_q.info, r_q.sec_num};
          r_d.rsv_lat = r_q.reserved_field;
          r_d.row = 4'h0;
          r_d.col = 8'h00;
          r_d.st = SDF_ST_HEAD;
        end
      end
      SDF_ST_HEAD: begin
        if (can_load) begin
          emit = 1'b1;
          r_d.out_data = head_byte;
          r_d.out_first = (r_q.col == 8'h00);
          r_d.out_last = 1'b0;
          core.crc_step = 1'b1;
          core.crc_byte = head_byte;
          if (r_q.col == SDF_HEAD_LAST_COL) begin
            r_d.st = SDF_ST_DATA;
          end
        end
      end
      SDF_ST_DATA: begin
        if (can_load && user_valid) begin
          emit = 1'b1;
          r_d.out_data = user_data;
          r_d.out_first = 1'b0;
          r_d.out_last = 1'b0;
          core.crc_step = 1'b1;
          core.crc_byte = user_data;
          if (r_q.row == SDF_LAST_ROW && r_q.col == SDF_USER_LAST_COL_END) begin
            r_d.st = SDF_ST_EDC;
          end
        end
      end
      SDF_ST_EDC: begin
        if (can_load) begin
          emit = 1'b1;
          r_d.out_data = edc_byte;
          r_d.out_first = 1'b0;
          // frame ends at row 11 column 171
          r_d.out_last = (r_q.col == SDF_LAST_COL);
          if (r_q.col == SDF_LAST_COL) begin
            r_d.st = SDF_ST_IDLE;
            r_d.frames = r_q.frames + 32'h0000_0001;
            r_d.last_edc = core.crc_word;
            if (r_q.auto_inc) begin
              r_d.sec_num = r_q.sec_num + 24'h00_0001;
            end
          end
        end
      end
      default: begin
        r_d.st = SDF_ST_IDLE;
      end
    endcase

    if (emit) begin
      r_d.out_valid = 1'b1;
      r_d.row = adv[11:8];
      r_d.col = adv[7:0];
    end

    // Write address and data are captured independently, in either order
    if (s_axi_awvalid && !r_q.aw_have) begin
      r_d.aw_have = 1'b1;
      r_d.aw_addr = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && !r_q.w_have) begin
      r_d.w_have = 1'b1;
      r_d.wdata = s_axi_wdata;
      r_d.wstrb = s_axi_wstrb;
    end

    // Register write once both halves are held; software write beats auto increment
    if (r_q.aw_have && r_q.w_have && !r_q.bvalid) begin
      r_d.aw_have = 1'b0;
      r_d.w_have = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = SDF_RESP_OKAY;
      case (sdf_word_addr(r_q.aw_addr))
        SDF_REG_CTRL: begin
          {r_d.auto_inc, r_d.enable} = 2'(sdf_merge({30'h0, r_q.auto_inc, r_q.enable}, r_q.wdata, r_q.wstrb));
        end
        SDF_REG_SECTOR_NUM: begin
          r_d.sec_num = 24'(sdf_merge({8'h00, r_q.sec_num}, r_q.wdata, r_q.wstrb));
        end
        SDF_REG_SECTOR_INFO: begin
          r_d.info = 4'(sdf_merge({28'h0, r_q.info}, r_q.wdata, r_q.wstrb));
        end
        SDF_REG_RSV_HI: begin
          r_d.reserved_field[47:32] = 16'(sdf_merge({16'h0, r_q.reserved_field[47:32]}, r_q.wdata, r_q.wstrb));
        end
        SDF_REG_RSV_LO: begin
          r_d.reserved_field[31:0] = sdf_merge(r_q.reserved_field[31:0], r_q.wdata, r_q.wstrb);
        end
        SDF_REG_STATUS, SDF_REG_FRAMES, SDF_REG_LAST_EDC: begin
          // Read-only words ignore writes
          r_d.bresp = SDF_RESP_OKAY;
        end
        default: begin
          r_d.bresp = SDF_RESP_SLVERR;
        end
      endcase
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end

    // Register read, answer registered one cycle after the address is taken
    if (s_axi_arvalid && !r_q.rvalid) begin
      r_d.rvalid = 1'b1;
      r_d.rresp = SDF_RESP_OKAY;
      r_d.rdata = 32'h0000_0000;
      case (sdf_word_addr(8'(s_axi_araddr)))
        SDF_REG_CTRL: r_d.rdata = {30'h0, r_q.auto_inc, r_q.enable};
        SDF_REG_SECTOR_NUM: r_d.rdata = {8'h00, r_q.sec_num};
        SDF_REG_SECTOR_INFO: r_d.rdata = {28'h0, r_q.info};
        SDF_REG_RSV_HI: r_d.rdata = {16'h0, r_q.reserved_field[47:32]};
        SDF_REG_RSV_LO: r_d.rdata = r_q.reserved_field[31:0];
        SDF_REG_STATUS: r_d.rdata = {8'h00, r_q.col, 4'h0, r_q.row, 6'h0, r_q.st};
        SDF_REG_FRAMES: r_d.rdata = r_q.frames;
        SDF_REG_LAST_EDC: r_d.rdata = r_q.last_edc;
        default: r_d.rresp = SDF_RESP_SLVERR;
      endcase
    end
    if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Bus readies are combinational, valids and data from flops
  assign s_axi_awready = !r_q.aw_have;
  assign s_axi_wready = !r_q.w_have;
  assign s_axi_bvalid = r_q.bvalid;
  assign s_axi_bresp = r_q.bresp;
  assign s_axi_arready = !r_q.rvalid;
  assign s_axi_rvalid = r_q.rvalid;
  assign s_axi_rdata = r_q.rdata;
  assign s_axi_rresp = r_q.rresp;
  assign frame_valid = r_q.out_valid;
  assign frame_data = r_q.out_data;
  assign frame_first = r_q.out_first;
  assign frame_last = r_q.out_last;
endmodule

// >>> tb/sdf_frame_builder_chk.sv
module sdf_fb_chk import sdf_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] user_data,
  input wire logic user_valid,
  input wire logic user_ready,
  input wire logic [7:0] frame_data,
  input wire logic frame_valid,
  input wire logic frame_first,
  input wire logic frame_last,
  input wire logic frame_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] cnt_q;

  // Bytes taken since frame start, so it is the index of the byte on show
  always_ff @(posedge ref_clk) begin
    if (reset || (frame_valid && frame_ready && frame_last)) begin
      cnt_q <= 12'h000;
    end else if (frame_valid && frame_ready) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Handshake steps of the two streams
  sequence s_out;
    frame_valid && frame_ready;
  endsequence
  sequence s_in;
    user_valid && user_ready;
  endsequence

  a_out_hold: assert property (frame_valid && !frame_ready |=>
    frame_valid && $stable({frame_data, frame_first, frame_last})) else $error("frame byte moved before taken");
  a_first_pos: assert property (frame_valid |-> frame_first == (cnt_q == 12'h000))
    else $error("first marker misplaced");
  a_last_pos: assert property (frame_valid |-> frame_last == (cnt_q == 12'h80f))
    else $error("last marker misplaced");
  a_fixed_bits: assert property (s_out ##0 frame_first |-> frame_data[7:4] == 4'h2)
    else $error("fixed sector bits wrong");
  a_user_echo: assert property (s_in |=> frame_valid && frame_data == $past(user_data))
    else $error("user byte not shown next cycle");
  a_user_slot: assert property (s_in |=> cnt_q >= 12'h00c && cnt_q <= 12'h80b)
    else $error("user byte outside payload");
  a_head_closed: assert property (frame_valid && cnt_q < 12'h00b |-> !user_ready)
    else $error("user taken in header");
  a_tail_closed: assert property (frame_valid && cnt_q >= 12'h80b |-> !user_ready)
    else $error("user taken in check word");
  a_reset_idle: assert property (disable iff (1'b0) reset |=> !frame_valid && !user_ready)
    else $error("reset left stream active");
endmodule

// >>> tb/sdf_stream_partner.sv
module sdf_stream_partner (
  input wire logic ref_clk,
  input wire logic reset,
  output logic [7:0] user_data,
  output logic user_valid,
  input wire logic user_ready,
  input wire logic [7:0] frame_data,
  input wire logic frame_valid,
  input wire logic frame_first,
  input wire logic frame_last,
  output logic frame_ready,
  output logic [7:0] cap [0:2063],
  output int frames
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] k_q;
  logic [11:0] idx;
  int t;

  // Pattern mixes the high index bits in, so swapped blocks show up
  assign user_data = k_q[7:0] ^ {5'h00, k_q[10:8]};

  // Source and stalling sink; sink stalls one cycle in seven
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      k_q <= 11'h000;
      idx <= 12'h000;
      user_valid <= 1'b0;
      frame_ready <= 1'b0;
      frames <= 0;
      t <= 0;
    end else begin
      t <= t + 1;
      frame_ready <= (t % 7) != 3;
      user_valid <= 1'b1;
      if (user_valid && user_ready) begin
        k_q <= k_q + 11'h001;
      end
      if (frame_valid && frame_ready) begin
        cap[frame_first ? 12'h000 : idx] <= frame_data;
        idx <= frame_first ? 12'h001 : idx + 12'h001;
        if (frame_last) begin
          frames <= frames + 1;
        end
      end
    end
  end
endmodule

// >>> tb/sdf_frame_builder_tb.sv
module sdf_frame_builder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sdf_pkg::*;
  logic ref_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, user_valid, user_ready;
  logic frame_valid, frame_first, frame_last, frame_ready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, user_data, frame_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] cap [0:2063];
  logic [7:0] ex [0:2063];
  int frames, error_cnt, samples_checked;

  sdf_frame_builder dut (
    .ref_clk(ref_clk),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .user_data(user_data),
    .user_valid(user_valid),
    .user_ready(user_ready),
    .frame_data(frame_data),
    .frame_valid(frame_valid),
    .frame_first(frame_first),
    .frame_last(frame_last),
    .frame_ready(frame_ready)
  );
  sdf_stream_partner partner (
    .ref_clk(ref_clk),
    .reset(reset),
    .user_data(user_data),
    .user_valid(user_valid),
    .user_ready(user_ready),
    .frame_data(frame_data),
    .frame_valid(frame_valid),
    .frame_first(frame_first),
    .frame_last(frame_last),
    .frame_ready(frame_ready),
    .cap(cap),
    .frames(frames)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic at, wt;
    at = 1'b0;
    wt = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(at && wt)) begin
      @(negedge ref_clk);
      at |= s_axi_awvalid && s_axi_awready;
      wt |= s_axi_wvalid && s_axi_wready;
      @(posedge ref_clk);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
    end
    do @(negedge ref_clk); while (!s_axi_bvalid);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge ref_clk); while (!s_axi_arready);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (!s_axi_rvalid);
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p ^= a;
      a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1d : 8'h00);
    end
    return p;
  endfunction

  // One frame with given attributes; enable drops once it starts
  task automatic frame(input logic [23:0] sn, input logic [3:0] inf, input logic [47:0] reserved_field, input logic ai);
    logic [31:0] id, c;
    logic [7:0] r1, r0, fb;
    int n;
    wchk(SDF_REG_SECTOR_NUM, {8'h00, sn}, SDF_RESP_OKAY);
    wchk(SDF_REG_SECTOR_INFO, {28'h0, inf}, SDF_RESP_OKAY);
    wchk(SDF_REG_RSV_HI, {16'h0, reserved_field[47:32]}, SDF_RESP_OKAY);
    wchk(SDF_REG_RSV_LO, reserved_field[31:0], SDF_RESP_OKAY);
    n = frames;
    wchk(SDF_REG_CTRL, {30'h0, ai, 1'b1}, SDF_RESP_OKAY);
    do @(negedge ref_clk); while (!(frame_valid && frame_first));
    wchk(SDF_REG_CTRL, {30'h0, ai, 1'b0}, SDF_RESP_OKAY);
    wchk(SDF_REG_SECTOR_INFO, {28'h0, ~inf}, SDF_RESP_OKAY);
    do @(negedge ref_clk); while (frames == n);
    id = {4'h2, inf, sn};
    r1 = 8'h00;
    r0 = 8'h00;
    for (int i = 0; i < 4; i++) begin
      ex[i] = id[31 - 8 * i -: 8];
      fb = ex[i] ^ r1;
      r1 = r0 ^ gm(fb, 8'h03);
      r0 = gm(fb, 8'h02);
    end
    ex[4] = r1;
    ex[5] = r0;
    for (int i = 0; i < 6; i++) ex[6 + i] = reserved_field[47 - 8 * i -: 8];
    for (int k = 0; k < 2048; k++) ex[12 + k] = k[7:0] ^ {5'h00, k[10:8]};
    c = 32'h0;
    for (int i = 0; i < 2060; i++) begin
      for (int b = 7; b >= 0; b--) c = {c[30:0], 1'b0} ^ ((c[31] ^ ex[i][b]) ? 32'h8000_0011 : 32'h0);
    end
    for (int i = 0; i < 4; i++) ex[2060 + i] = c[31 - 8 * i -: 8];
    for (int i = 0; i < 2064; i++) chk("frame byte", {24'h0, ex[i]}, {24'h0, cap[i]});
    rchk(SDF_REG_LAST_EDC, c, SDF_RESP_OKAY);
    rchk(SDF_REG_SECTOR_NUM, {8'h00, sn + {23'h0, ai}}, SDF_RESP_OKAY);
    $display("frame test done sector %h info %h", sn, inf);
  endtask

  initial begin
    reset = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(SDF_REG_SECTOR_NUM, 32'h0, SDF_RESP_OKAY);
    rchk(SDF_REG_STATUS, 32'h0, SDF_RESP_OKAY);
    rchk(SDF_REG_CTRL, 32'h0, SDF_RESP_OKAY);
    wchk(SDF_REG_SECTOR_NUM, 32'h0012_3456, SDF_RESP_OKAY);
    s_axi_wstrb <= 4'h2;
    wchk(SDF_REG_SECTOR_NUM, 32'hffff_abff, SDF_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rchk(SDF_REG_SECTOR_NUM, 32'h0012_ab56, SDF_RESP_OKAY);
    wchk(SDF_REG_FRAMES, 32'h0000_0005, SDF_RESP_OKAY);
    rchk(SDF_REG_FRAMES, 32'h0, SDF_RESP_OKAY);
    wchk(8'h20, 32'h1, SDF_RESP_SLVERR);
    rchk(8'h20, 32'h0, SDF_RESP_SLVERR);
    $display("register test done");
    // Every zone code, both data types and both layers
    for (int i = 0; i < 4; i++) begin
      frame(i == 3 ? 24'hfffff0 : 24'h000010 << i, {i[1:0], i[0], ~i[1]}, i == 0 ? 48'h0 : 48'h1234_89ab_cdef, i[0]);
    end
    rchk(SDF_REG_FRAMES, 32'h4, SDF_RESP_OKAY);
    // Reset in mid-frame, then a clean frame
    wchk(SDF_REG_CTRL, 32'h1, SDF_RESP_OKAY);
    repeat (300) @(posedge ref_clk);
    reset <= 1'b1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(SDF_REG_FRAMES, 32'h0, SDF_RESP_OKAY);
    rchk(SDF_REG_STATUS, 32'h0, SDF_RESP_OKAY);
    frame(24'h000100, 4'h5, 48'h0, 1'b0);
    final_report;
  end

  // Hang guard, well beyond five frames with stalls
  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    final_report;
  end
endmodule

bind sdf_frame_builder sdf_fb_chk u_chk (
  .ref_clk(ref_clk),
  .reset(reset),
  .user_data(user_data),
  .user_valid(user_valid),
  .user_ready(user_ready),
  .frame_data(frame_data),
  .frame_valid(frame_valid),
  .frame_first(frame_first),
  .frame_last(frame_last),
  .frame_ready(frame_ready)
);
